// *** pmsm_ctrl.sv ***
`timescale 1ns/10ps
module pmsm_ctrl
  import pmsm_pkg::*;
#(
  parameter int RST_DLY = pmsm_pkg::RESET_DELAY_CYC
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RESET,
  input  wire logic                SPI_CLK,
  input  wire logic                SPI_SEL_N,
  input  wire logic                SPI_MOSI,
  input  wire pmsm_pkg::pmsm_pins_t PINS,
  input  wire logic                WATCHDOG_FAULT_COUNT_EV,
  input  wire logic                CFG_FO_FIRST,
  input  wire logic                FS_ENTER,
  input  wire logic                FS_EXIT,
  output pmsm_pkg::pmsm_cfg_t      SETTINGS,
  output logic                     MAIN_SUPPLY_EN,
  output logic                     WD_ENABLE,
  output logic                     CYCLIC_WAKE_EN,
  output logic                     WD_LONG_START,
  output logic                     WD_REFRESH,
  output logic                     FAIL_OUT,
  output logic                     RESET_OUT_N,
  output logic                     WAKE_IRQ,
  output logic [1:0]               MODE_BITS,
  output logic [1:0]               DEVICE_STATE,
  output logic [1:0]               WD_FAULT_COUNT,
  output logic [2:0]               WAKE_FLAGS_A,
  output logic [1:0]               WAKE_FLAGS_B,
  output logic                     UV_FLAG,
  output logic                     OV_FLAG,
  output logic                     REJECT_FLAG
);
  import pmsm_pkg::*;

  // transceiver state after restart
  function automatic pmsm_trx_t trx_restart(input pmsm_trx_t t);
    trx_restart = (t == TRX_OFF) ? TRX_OFF : TRX_WAKE;
  endfunction : trx_restart

  // transceiver state on sleep entry; off stays off
  function automatic pmsm_trx_t trx_sleep(input pmsm_trx_t t);
    trx_sleep = (t == TRX_ON || t == TRX_RXONLY) ? TRX_WAKE : t;
  endfunction : trx_sleep

  // ---- link domain: shift in 16-bit frames ----
  logic [3:0]       bit_cnt;
  logic [SPI_W-1:0] shift;
  logic [SPI_W-1:0] link_word;
  logic             link_tgl;

  // deselect clears the count, so no edge after a frame is needed
  always_ff @(posedge SPI_CLK or posedge SPI_SEL_N) begin
    if (SPI_SEL_N) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge SPI_CLK) begin
    shift <= {shift[SPI_W-2:0], SPI_MOSI};
  end

  // word held stable until the next frame completes
  always_ff @(posedge SPI_CLK or posedge RESET) begin
    if (RESET) begin
      link_word <= '0;
      link_tgl  <= 1'b0;
    end else if (bit_cnt == 4'hf) begin
      link_word <= {shift[SPI_W-2:0], SPI_MOSI};
      link_tgl  <= ~link_tgl;
    end
  end

  // ---- crossings into the system domain ----
  logic [2:0]  tgl_s;
  pmsm_pins_t  pin_s1;
  pmsm_pins_t  pin_s2;
  pmsm_pins_t  pin_s3;
  logic [SPI_W-1:0] cmd_word;

  // toggle and pins pass two flops; the third stage finds edges
  always_ff @(posedge SYS_CLK) begin
    tgl_s  <= {tgl_s[1:0], link_tgl};
    pin_s1 <= PINS;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    if (tgl_s[2] != tgl_s[1]) begin
      cmd_word <= link_word;
    end
  end

  logic cmd_new;
  logic cmd_v;
  logic [2:0] cmd_op;
  logic [11:0] cmd_d;
  assign cmd_new = RESET ? 1'b0 : (tgl_s[2] != tgl_s[1]);

  // decode one cycle after capture, from the registered word
  always_ff @(posedge SYS_CLK) begin
    cmd_v <= RESET ? 1'b0 : cmd_new;
  end
  assign cmd_op = cmd_word[CMD_HI:CMD_LO];
  assign cmd_d  = cmd_word[11:0];

  // event edges
  logic [2:0] pin_wk_ev;
  logic       can_ev;
  logic       lin_ev;
  logic       uv_ev;
  logic       ov_ev;
  logic       wake_ev;
  assign pin_wk_ev = pin_s2.wake_pins & ~pin_s3.wake_pins
                     & SETTINGS.wake_pin_en;
  assign can_ev = pin_s2.can_wake & ~pin_s3.can_wake
                  & (SETTINGS.can_mode != TRX_OFF);
  assign lin_ev = pin_s2.lin_wake & ~pin_s3.lin_wake
                  & (SETTINGS.lin_mode != TRX_OFF);
  assign uv_ev  = pin_s2.uvolt & ~pin_s3.uvolt;
  assign ov_ev  = pin_s2.ovolt & ~pin_s3.ovolt;
  assign wake_ev = (|pin_wk_ev) | can_ev | lin_ev;

  // ---- main controller state ----
  pmsm_mode_t mode, next_mode;
  pmsm_cfg_t  cfg, next_cfg;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0] wfa, next_wfa;
  logic [1:0] wfb, next_wfb;
  logic uv_f, next_uv_f;
  logic ov_f, next_ov_f;
  logic rej, next_rej;
  logic [1:0] dev_st, next_dev_st;
  logic [1:0] wdc, next_wdc;
  logic fo_lat, next_fo_lat;
  logic [1:0] mbits, next_mbits;
  logic from_sleep, next_from_sleep;
  logic irq, next_irq;
  logic ro_n, next_ro_n;
  logic wd_long, next_wd_long;
  logic wd_ref, next_wd_ref;
  logic strap, next_strap;
  logic main_en, next_main_en;
  logic wd_en, next_wd_en;
  logic go_rst;
  logic go_fs;
  logic [1:0] wdc_inc;
  logic wd_last;
  logic spi_ok;
  logic is_mode;
  logic [1:0] mreq;
  logic any_flag;
  logic no_src;
  logic ev_hi;

  assign wdc_inc  = (wdc == WDF_TWO) ? WDF_TWO : wdc + 2'h1;
  assign wd_last  = CFG_FO_FIRST || (wdc_inc == WDF_TWO);
  assign spi_ok   = cmd_v && cmd_word[CMD_WR_BIT];
  assign is_mode  = spi_ok && (cmd_op == CMD_MODE);
  assign mreq     = cmd_d[1:0];
  assign any_flag = (|wfa) || (|wfb);
  assign no_src   = (cfg.can_mode == TRX_OFF)
                    && (cfg.lin_mode == TRX_OFF)
                    && (cfg.wake_pin_en == 3'h0);
  // events that outrank host commands in normal and stop
  assign ev_hi = FS_ENTER || uv_ev
                 || (ov_ev && cfg.ov_rst_en) || WATCHDOG_FAULT_COUNT_EV;

  always_comb begin
    next_mode = mode;
    next_cfg = cfg;
    next_cnt = cnt;
    next_wfa = wfa;
    next_wfb = wfb;
    next_uv_f = uv_f;
    next_ov_f = ov_f;
    next_rej = rej;
    next_dev_st = dev_st;
    next_wdc = wdc;
    next_fo_lat = fo_lat;
    next_mbits = mbits;
    next_from_sleep = from_sleep;
    next_strap = strap;
    next_ro_n = ro_n;
    next_irq = 1'b0;
    next_wd_long = 1'b0;
    next_wd_ref = 1'b0;
    go_rst = 1'b0;
    go_fs = 1'b0;

    // host clears first so that a same-cycle set below wins
    if (spi_ok && cmd_op == CMD_CLR && mode != PM_RESTART
        && mode != PM_BOOT) begin
      if (cmd_d[F_CLR_WAKE]) begin
        next_wfa = 3'h0;
        next_wfb = 2'h0;
      end
      if (cmd_d[F_CLR_SUP]) begin
        next_uv_f = 1'b0;
        next_ov_f = 1'b0;
        next_wdc  = 2'h0;
      end
      if (cmd_d[F_CLR_REJ]) begin
        next_rej = 1'b0;
      end
    end

    // wake sources are recorded in normal, stop and sleep only
    if (mode inside {PM_NORMAL, PM_STOP, PM_SLEEP}) begin
      next_wfa = next_wfa | pin_wk_ev;
      next_wfb = next_wfb | {lin_ev, can_ev};
    end

    unique case (mode)
      PM_BOOT, PM_RESTART: begin
        next_ro_n = 1'b0;
        if (cnt == CNT_W'(RST_DLY - 1)) begin
          next_ro_n = 1'b1;
          next_wd_long = 1'b1;
          next_cfg.wd_period = WD_PER_DEF;
          next_strap = pin_s2.strap;
          if (mode == PM_RESTART) begin
            next_mode = PM_NORMAL;
            next_mbits = MREQ_NORMAL;
            next_dev_st = from_sleep ? DEV_SLEEP
                                     : DEV_RESTART;
          end else begin
            next_mode = PM_INIT;
          end
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
      PM_INIT: begin
        // any frame leaves init with everything off
        if (cmd_v) begin
          next_mode = PM_NORMAL;
          next_cfg = '0;
          next_cfg.wd_period = WD_PER_DEF;
          next_fo_lat = 1'b0;
          next_mbits = MREQ_NORMAL;
        end
      end
      PM_NORMAL, PM_STOP: begin
        if (FS_ENTER) begin
          go_fs = 1'b1;
        end else if (uv_ev) begin
          next_uv_f = 1'b1;
          go_rst = 1'b1;
        end else if (ov_ev && cfg.ov_rst_en) begin
          next_ov_f = 1'b1;
          next_fo_lat = 1'b1;
          go_rst = strap;
          go_fs = ~strap;
        end else if (WATCHDOG_FAULT_COUNT_EV) begin
          next_wdc = wdc_inc;
          next_fo_lat = fo_lat | wd_last;
          go_fs = ~strap && wd_last;
          go_rst = ~go_fs;
        end else if (is_mode) begin
          // judged on this cycle's flags and enables
          next_mbits = mreq;
          if (mreq == MREQ_SRST) begin
            go_rst = 1'b1;
          end else if (mreq == MREQ_NORMAL) begin
            next_mode = PM_NORMAL;
          end else if (mode == PM_STOP) begin
            next_rej = 1'b1;
            go_rst = (mreq == MREQ_SLEEP);
          end else if (mreq == MREQ_STOP) begin
            next_mode = PM_STOP;
            next_irq = any_flag;
          end else if (no_src) begin
            next_rej = 1'b1;
            go_rst = 1'b1;
          end else if (any_flag) begin
            go_rst = 1'b1;
            next_from_sleep = 1'b1;
          end else begin
            next_mode = PM_SLEEP;
            next_dev_st = DEV_SLEEP;
            next_cfg.can_mode = trx_sleep(cfg.can_mode);
            next_cfg.lin_mode = trx_sleep(cfg.lin_mode);
          end
        end else if (spi_ok && cmd_op == CMD_WDREF) begin
          next_wd_ref = 1'b1;
        end else if (spi_ok && mode == PM_STOP
                     && cmd_op != CMD_CLR) begin
          next_rej = 1'b1;
        end else if (spi_ok && cmd_op == CMD_CFG) begin
          next_cfg.can_mode    = pmsm_trx_t'(cmd_d[F_CAN+:2]);
          next_cfg.lin_mode    = pmsm_trx_t'(cmd_d[F_LIN+:2]);
          next_cfg.wake_pin_en = cmd_d[F_WKP+:3];
          next_cfg.aux_on      = cmd_d[F_AUX];
          next_cfg.third_on    = cmd_d[F_THR];
          next_cfg.hs_on       = cmd_d[F_HS];
          next_cfg.fo_test     = cmd_d[F_FOT];
          next_cfg.ov_rst_en   = cmd_d[F_OVR];
        end else if (spi_ok && cmd_op == CMD_WDCFG) begin
          next_cfg.wd_period = cmd_d[2:0];
          next_cfg.cyc_wake  = cmd_d[F_CYC];
        end
        // alert only; a wake never changes the mode here
        if (wake_ev && !go_rst && !go_fs) begin
          next_irq = 1'b1;
        end
      end
      PM_SLEEP: begin
        if (FS_ENTER) begin
          go_fs = 1'b1;
        end else if (wake_ev) begin
          go_rst = 1'b1;
          next_from_sleep = 1'b1;
        end
      end
      PM_FAILSAFE: begin
        if (FS_EXIT) begin
          go_rst = 1'b1;
        end
      end
    endcase

    if (go_fs) begin
      next_mode = PM_FAILSAFE;
      next_fo_lat = 1'b1;
      next_from_sleep = 1'b0;
      next_ro_n = 1'b0;
    end else if (go_rst) begin
      // restart entry: reset low, aux and high-side dropped
      next_mode = PM_RESTART;
      next_cnt = '0;
      next_ro_n = 1'b0;
      next_cfg.aux_on = 1'b0;
      next_cfg.hs_on = 1'b0;
      next_cfg.fo_test = 1'b0;
      next_cfg.can_mode = trx_restart(next_cfg.can_mode);
      next_cfg.lin_mode = trx_restart(next_cfg.lin_mode);
      if (mode != PM_SLEEP && !next_from_sleep) begin
        next_from_sleep = 1'b0;
      end
    end
    if (next_mode == PM_NORMAL && mode == PM_RESTART) begin
      next_from_sleep = 1'b0;
    end

    // derived enables follow the mode being entered
    next_main_en = !(next_mode inside {PM_SLEEP, PM_FAILSAFE});
    next_wd_en = next_mode inside {PM_INIT, PM_NORMAL, PM_STOP};
  end

  // register the controller state
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mode <= PM_BOOT;
      cfg <= '0;
      cnt <= '0;
      wfa <= '0;
      wfb <= '0;
      uv_f <= 1'b0;
      ov_f <= 1'b0;
      rej <= 1'b0;
      dev_st <= DEV_NONE;
      wdc <= '0;
      fo_lat <= 1'b0;
      mbits <= MREQ_NORMAL;
      from_sleep <= 1'b0;
      irq <= 1'b0;
      ro_n <= 1'b0;
      wd_long <= 1'b0;
      wd_ref <= 1'b0;
      strap <= 1'b0;
      main_en <= 1'b1;
      wd_en <= 1'b0;
    end else begin
      mode <= next_mode;
      cfg <= next_cfg;
      cnt <= next_cnt;
      wfa <= next_wfa;
      wfb <= next_wfb;
      uv_f <= next_uv_f;
      ov_f <= next_ov_f;
      rej <= next_rej;
      dev_st <= next_dev_st;
      wdc <= next_wdc;
      fo_lat <= next_fo_lat;
      mbits <= next_mbits;
      from_sleep <= next_from_sleep;
      irq <= next_irq;
      ro_n <= next_ro_n;
      wd_long <= next_wd_long;
      wd_ref <= next_wd_ref;
      strap <= next_strap;
      main_en <= next_main_en;
      wd_en <= next_wd_en;
    end
  end

  // outputs
  assign SETTINGS = cfg;
  assign MAIN_SUPPLY_EN = main_en;
  assign WD_ENABLE = wd_en;
  assign CYCLIC_WAKE_EN = cfg.cyc_wake & wd_en;
  assign WD_LONG_START = wd_long;
  assign WD_REFRESH = wd_ref;
  assign FAIL_OUT = fo_lat | cfg.fo_test;
  assign RESET_OUT_N = ro_n;
  assign WAKE_IRQ = irq;
  assign MODE_BITS = mbits;
  assign DEVICE_STATE = dev_st;
  assign WD_FAULT_COUNT = wdc;
  assign WAKE_FLAGS_A = wfa;
  assign WAKE_FLAGS_B = wfb;
  assign UV_FLAG = uv_f;
  assign OV_FLAG = ov_f;
  assign REJECT_FLAG = rej;

  // watchdog period back at its default, read by the exit check
  logic wd_per_ok;
  assign wd_per_ok = (cfg.wd_period == WD_PER_DEF);

  // checks
  wake_alert_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_NORMAL && wake_ev && !ev_hi && !is_mode)
    |=> WAKE_IRQ && mode == PM_NORMAL)
    else $error("wake in normal did not alert or changed mode");
  stop_freeze_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_STOP && spi_ok && cmd_op == CMD_CFG && !ev_hi)
    |=> REJECT_FLAG && $stable(SETTINGS))
    else $error("config write accepted in stop");
  stop_sleep_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_STOP && is_mode && mreq == MREQ_SLEEP && !ev_hi)
    |=> mode == PM_RESTART && REJECT_FLAG)
    else $error("stop to sleep not refused");
  sleep_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_SLEEP) |-> !MAIN_SUPPLY_EN && !WD_ENABLE
    && !CYCLIC_WAKE_EN)
    else $error("supply or watchdog on in sleep");
  restart_low_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(mode == PM_RESTART) |-> !RESET_OUT_N [*4])
    else $error("reset output released early");
  restart_exit_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_RESTART ##1 mode == PM_NORMAL)
    |-> MODE_BITS == MREQ_NORMAL && RESET_OUT_N && WD_LONG_START
    && wd_per_ok)
    else $error("restart exit left wrong state");
  uv_restart_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode inside {PM_NORMAL, PM_STOP} && uv_ev && !FS_ENTER)
    |=> UV_FLAG && mode == PM_RESTART && !RESET_OUT_N)
    else $error("undervolt did not restart");
  fo_keep_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_RESTART && fo_lat) |=> FAIL_OUT)
    else $error("fail outputs dropped by restart");
  no_src_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == PM_NORMAL && is_mode && mreq == MREQ_SLEEP && no_src
    && !ev_hi) |=> REJECT_FLAG && mode == PM_RESTART)
    else $error("sleep without wake source accepted");

endmodule : pmsm_ctrl

// *** pmsm_ctrl_tb_top.sv ***
`timescale 1ns/10ps
module pmsm_ctrl_tb_top;
  import pmsm_pkg::*;
  logic       sys_clk, reset, spi_clk, spi_sel_n, spi_mosi;
  pmsm_pins_t pins;
  logic       watchdog_fault_count_ev, cfg_fo_first, fs_enter, fs_exit;
  pmsm_cfg_t  settings, held;
  logic       main_en, wd_en, cyc_en, wd_long, fail_out, rst_n, irq, wd_ref;
  logic [1:0] mode_bits, dev_state, wd_cnt, flags_b;
  logic [2:0] flags_a;
  logic       uv, ov, rej;
  int         failures, total_checks, irqs, irq0, refs;
  wire  [3:0] trx = {settings.can_mode, settings.lin_mode};
  wire  [2:0] sw = {settings.aux_on, settings.third_on, settings.hs_on};

  pmsm_host host (.SPI_CLK(spi_clk), .SPI_SEL_N(spi_sel_n),
    .SPI_MOSI(spi_mosi));
  pmsm_ctrl #(.RST_DLY(8)) DUT (
    .SYS_CLK(sys_clk), .RESET(reset), .SPI_CLK(spi_clk),
    .SPI_SEL_N(spi_sel_n), .SPI_MOSI(spi_mosi), .PINS(pins),
    .WATCHDOG_FAULT_COUNT_EV(watchdog_fault_count_ev), .CFG_FO_FIRST(cfg_fo_first),
    .FS_ENTER(fs_enter), .FS_EXIT(fs_exit), .SETTINGS(settings),
    .MAIN_SUPPLY_EN(main_en), .WD_ENABLE(wd_en),
    .CYCLIC_WAKE_EN(cyc_en), .WD_LONG_START(wd_long), .WD_REFRESH(wd_ref),
    .FAIL_OUT(fail_out), .RESET_OUT_N(rst_n), .WAKE_IRQ(irq),
    .MODE_BITS(mode_bits), .DEVICE_STATE(dev_state),
    .WD_FAULT_COUNT(wd_cnt), .WAKE_FLAGS_A(flags_a),
    .WAKE_FLAGS_B(flags_b), .UV_FLAG(uv), .OV_FLAG(ov),
    .REJECT_FLAG(rej)
  );

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // wake alert and refresh are one-cycle pulses, so count them as they happen
  always @(posedge sys_clk) begin
    if (irq === 1'b1) irqs++;
    if (wd_ref === 1'b1) refs++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // bounded wait on the reset output; release must start the long window
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    while (rst_n !== v && n < 400) begin
      step(1);
      n++;
    end
    if (n == 400) begin
      failures++;
      complete_run();
    end else if (v) begin
      check("long window", wd_long, 1'b1);
    end
  endtask : wait_rst

  // frames spaced a little beyond 16 link clocks; effects land within 6 cycles
  task automatic wr(input logic [2:0] op, input logic [11:0] d);
    step(48);
    host.send({1'b1, op, d});
    step(6);
  endtask : wr

  task automatic mode(input logic [1:0] m);
    wr(CMD_MODE, {10'h000, m});
  endtask : mode

  initial begin
    // a clean low-to-high step so the link-side reset always fires
    reset = 1'b0;
    #1;
    reset = 1'b1;
    pins = '0;
    pins.strap = 1'b1;
    {watchdog_fault_count_ev, fs_enter, fs_exit} = 3'b000;
    cfg_fo_first = 1'b1;
    step(16);
    check("reset", {rst_n, main_en}, 2'b01);
    reset = 1'b0;
    wait_rst(1'b1);
    // first frame leaves init with everything off
    wr(CMD_WDREF, 12'h000);
    check("init", {trx, sw, fail_out, mode_bits}, 10'h000);
    wr(CMD_CFG, 12'h400);
    check("fo test on", fail_out, 1'b1);
    wr(CMD_CFG, 12'h000);
    check("fo test off", fail_out, 1'b0);
    // can on, lin rx-only, wake pins and all switches on
    wr(CMD_CFG, 12'h3fb);
    // period 3 and cyclic wake on, so restart and sleep have work to do
    wr(CMD_WDCFG, 12'h00b);
    check("cyclic on", cyc_en, 1'b1);
    irq0 = irqs;
    pins.can_wake = 1'b1;
    step(10);
    pins.can_wake = 1'b0;
    check("wake irq", 16'(irqs - irq0), 16'h1);
    check("wake mode", {flags_b, mode_bits}, 4'b0100);
    // stop entry with a wake flag still pending
    held = settings;
    irq0 = irqs;
    mode(MREQ_STOP);
    check("stop irq", 16'(irqs - irq0), 16'h1);
    check("stop mode", mode_bits, MREQ_STOP);
    wr(CMD_CFG, 12'h000);
    check("stop reject", rej, 1'b1);
    check("stop frozen", settings, held);
    wr(CMD_CLR, 12'h005);
    check("stop clear", {rej, flags_b}, 3'b000);
    wr(CMD_WDREF, 12'h000);
    check("stop refresh", 16'(refs), 16'h1);
    check("refresh no reject", rej, 1'b0);
    mode(MREQ_SLEEP);
    check("stop sleep", {rej, rst_n}, 2'b10);
    wait_rst(1'b1);
    step(2);
    check("rst mode", {mode_bits, dev_state}, 4'b0001);
    check("rst switches", sw, 3'b010);
    check("rst trx", trx, {TRX_WAKE, TRX_WAKE});
    check("wd period", settings.wd_period, WD_PER_DEF);
    // sleep, then a wake pin brings it back through restart
    wr(CMD_CLR, 12'h007);
    wr(CMD_CFG, 12'h073);
    mode(MREQ_SLEEP);
    check("sleep", {main_en, wd_en, cyc_en, fail_out}, 4'h0);
    check("sleep trx", trx, {TRX_WAKE, TRX_OFF});
    pins.wake_pins[0] = 1'b1;
    wait_rst(1'b0);
    wait_rst(1'b1);
    pins.wake_pins[0] = 1'b0;
    step(2);
    check("wake src", {main_en, flags_a[0], mode_bits}, 4'b1100);
    check("wake state", dev_state, DEV_SLEEP);
    // sleep with no wake source left is refused
    wr(CMD_CLR, 12'h007);
    wr(CMD_CFG, 12'h000);
    mode(MREQ_SLEEP);
    check("no source", {rej, rst_n}, 2'b10);
    wait_rst(1'b1);
    check("off trx", trx, 4'h0);
    // pending wake flag makes a sleep request wake at once
    wr(CMD_CFG, 12'h070);
    pins.wake_pins[1] = 1'b1;
    step(6);
    pins.wake_pins[1] = 1'b0;
    mode(MREQ_SLEEP);
    check("pending", rst_n, 1'b0);
    wait_rst(1'b1);
    step(2);
    check("pend state", {mode_bits, dev_state}, 4'b0010);
    // undervoltage on the main supply
    pins.uvolt = 1'b1;
    step(5);
    pins.uvolt = 1'b0;
    check("uv restart", rst_n, 1'b0);
    wait_rst(1'b1);
    check("uv flag", {uv, dev_state}, 3'b101);
    // first watchdog failure with fail outputs on the first one
    wr(CMD_CLR, 12'h002);
    watchdog_fault_count_ev = 1'b1;
    step(1);
    watchdog_fault_count_ev = 1'b0;
    step(3);
    check("wd restart", rst_n, 1'b0);
    wait_rst(1'b1);
    step(2);
    check("wd fault", {wd_cnt, fail_out}, 3'b011);
    // a second failure without a clear counts two
    watchdog_fault_count_ev = 1'b1;
    step(1);
    watchdog_fault_count_ev = 1'b0;
    wait_rst(1'b0);
    wait_rst(1'b1);
    check("wd second", wd_cnt, WDF_TWO);
    // strapped overvoltage with reset enabled
    wr(CMD_CFG, 12'h800);
    pins.ovolt = 1'b1;
    step(5);
    pins.ovolt = 1'b0;
    check("ov restart", rst_n, 1'b0);
    wait_rst(1'b1);
    check("ov flag", {ov, fail_out}, 2'b11);
    // fail-safe exit passes through restart; strap low is taken at release
    pins.strap = 1'b0;
    fs_enter = 1'b1;
    step(1);
    fs_enter = 1'b0;
    step(4);
    fs_exit = 1'b1;
    step(1);
    fs_exit = 1'b0;
    wait_rst(1'b0);
    wait_rst(1'b1);
    step(2);
    check("fs state", {mode_bits, dev_state}, 4'b0001);
    // strap low: overvoltage with reset enabled must not restart
    wr(CMD_CLR, 12'h002);
    pins.ovolt = 1'b1;
    step(5);
    pins.ovolt = 1'b0;
    check("ov fail-safe", {main_en, rst_n, ov}, 3'b001);
    complete_run();
  end
endmodule : pmsm_ctrl_tb_top

// *** pmsm_host.sv ***
`timescale 1ns/10ps
module pmsm_host (
  output logic SPI_CLK,
  output logic SPI_SEL_N,
  output logic SPI_MOSI
);
  // link clock stands low outside frames
  initial begin
    SPI_CLK = 1'b0;
    SPI_SEL_N = 1'b0;
    SPI_MOSI = 1'b0;
    // a real rising select clears the bit counter before any frame
    #1;
    SPI_SEL_N = 1'b1;
  end

  // one frame, msb first, 12 ns link period; mode requests ride here
  task automatic send(input logic [15:0] w);
    #3.3;
    SPI_SEL_N = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      SPI_MOSI = w[i];
      #6 SPI_CLK = 1'b1;
      #6 SPI_CLK = 1'b0;
    end
    #6 SPI_SEL_N = 1'b1;
    SPI_MOSI = ~SPI_MOSI; // released line must not look like held data
  endtask : send
endmodule : pmsm_host

// *** pmsm_pkg.sv ***
package pmsm_pkg;

  // operating modes of the controller
  typedef enum logic [2:0] {
    PM_BOOT, PM_INIT, PM_NORMAL, PM_STOP,
    PM_SLEEP, PM_RESTART, PM_FAILSAFE
  } pmsm_mode_t;

  // transceiver operating modes
  typedef enum logic [1:0] {
    TRX_OFF, TRX_WAKE, TRX_RXONLY, TRX_ON
  } pmsm_trx_t;

  // settings written by the host in normal mode
  typedef struct packed {
    pmsm_trx_t  can_mode;
    pmsm_trx_t  lin_mode;
    logic [2:0] wake_pin_en;
    logic       aux_on;
    logic       third_on;
    logic       hs_on;
    logic       fo_test;
    logic       ov_rst_en;
    logic       cyc_wake;
    logic [2:0] wd_period;
  } pmsm_cfg_t;

  // synchronised pin group
  typedef struct packed {
    logic       strap;
    logic       ovolt;
    logic       uvolt;
    logic       lin_wake;
    logic       can_wake;
    logic [2:0] wake_pins;
  } pmsm_pins_t;

  // serial frame layout
  localparam int SPI_W      = 16;
  localparam int CMD_WR_BIT = 15;
  localparam int CMD_HI     = 14;
  localparam int CMD_LO     = 12;
  localparam logic [2:0] CMD_MODE  = 3'h1;
  localparam logic [2:0] CMD_CFG   = 3'h2;
  localparam logic [2:0] CMD_WDCFG = 3'h3;
  localparam logic [2:0] CMD_WDREF = 3'h4;
  localparam logic [2:0] CMD_CLR   = 3'h5;

  // mode request codes, also the mode-select read-back
  localparam logic [1:0] MREQ_NORMAL = 2'h0;
  localparam logic [1:0] MREQ_SLEEP  = 2'h1;
  localparam logic [1:0] MREQ_STOP   = 2'h2;
  localparam logic [1:0] MREQ_SRST   = 2'h3;

  // field positions in config, watchdog-config and clear writes
  localparam int F_CAN = 0;
  localparam int F_LIN = 2;
  localparam int F_WKP = 4;
  localparam int F_AUX = 7;
  localparam int F_THR = 8;
  localparam int F_HS  = 9;
  localparam int F_FOT = 10;
  localparam int F_OVR = 11;
  localparam int F_CYC = 3;
  localparam int F_CLR_WAKE = 0;
  localparam int F_CLR_SUP  = 1;
  localparam int F_CLR_REJ  = 2;

  // status codes and reset values
  localparam logic [1:0] DEV_NONE    = 2'h0;
  localparam logic [1:0] DEV_RESTART = 2'h1;
  localparam logic [1:0] DEV_SLEEP   = 2'h2;
  localparam logic [1:0] WDF_ONE     = 2'h1;
  localparam logic [1:0] WDF_TWO     = 2'h2;
  localparam logic [2:0] WD_PER_DEF  = 3'h4;

  // timing
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RESET_DELAY_NS = 10000;
  localparam int RESET_DELAY_CYC =
    (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;

endpackage : pmsm_pkg
